//--- design/cwd_params.svh
// Register offsets, field positions, key values and rate exponents.
`ifndef CWD_PARAMS_SVH
`define CWD_PARAMS_SVH

`define CWD_OFS_CTRL 3'h0
`define CWD_OFS_ARM 3'h1
`define CWD_OFS_CFG 3'h2
`define CWD_OFS_STS 3'h3
`define CWD_OFS_MSK 3'h4
`define CWD_OFS_INFO 3'h5

`define CWD_BIT_WIN 7
`define CWD_BIT_HALT 6
`define CWD_BIT_MASK 5
`define CWD_KEY_FIRST 8'h55
`define CWD_KEY_SECOND 8'haa
`define CWD_RATE_OFF 3'h0
`define CWD_RATE_MAX 3'h7

`define CWD_EXP_1 5'h0e
`define CWD_EXP_2 5'h10
`define CWD_EXP_3 5'h12
`define CWD_EXP_4 5'h14
`define CWD_EXP_5 5'h16
`define CWD_EXP_6 5'h17
`define CWD_EXP_7 5'h18

`define CWD_RST_RATE 3'h0
`define CWD_RST_STS 3'h0
`define CWD_RST_MSK 3'h0

`endif

//--- design/cwd_pkg.sv
// Types shared by the watchdog control block.
package cwd_pkg;

  typedef struct packed {
    logic window;
    logic halt;
    logic [2:0] rate;
  } cwd_ctrl_t;

  typedef struct packed {
    logic special;
    logic debug;
    logic stop;
    logic pstop;
    logic osc_cont;
    logic osc_up;
  } cwd_sys_t;

  typedef struct packed {
    logic window_err;
    logic key_err;
    logic timeout;
  } cwd_evt_t;

endpackage : cwd_pkg

//--- design/cwd_top.sv
// Watchdog control logic with an Avalon-MM register slave.
`timescale 1ns/1ps
`include "cwd_params.svh"

// Functional notes
// - Halt bit free in special mode; normal mode may only set it.
// - Window and rate writes need mask 0: always special, once normal.
// - Normal write of rate 000 or window 0 changes nothing, uses write.
// - A nonzero rate loaded after reset starts the timeout period.
// - Any change of clock source select restarts the period.
// - Normal mode restarts on effective rate, window write, or halt rise.
// - Special mode: every control write restarts the period.
// - Window mode: arm writes in first 75 percent cause reset.
// - Repeated first keys allowed; second key after first restarts period.
// - Halt bit set freezes watchdog and periodic timer during debug.
// - Mask bit is write-only; set, it keeps window, rate and the once-write.
// - Nonzero rate enables counter; reaching timeout asserts system reset.
// - Special mode debug with halt 0 forces longest non-window period.
// - Rate 000 off; 001..111 give 2^14,16,18,20,22,23,24 cycles.
// - Enabled: other arm values reset; first then second key restarts.
// - Disabled: arm writes do nothing; arm reads return zero.
// - Stop halts counter unless pseudo-stop, oscillator source, continue.
module cwd_top #(
  parameter int CNT_W = 24
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire cwd_pkg::cwd_sys_t SYS,
  input wire logic IRC_TICK,
  input wire logic OSC_TICK,
  input wire logic NVM_LOAD,
  input wire cwd_pkg::cwd_ctrl_t NVM_CTRL,
  output logic SYS_RESET,
  output logic PERIODIC_FREEZE,
  output logic IRQ
);
  import cwd_pkg::*;

  if (CNT_W != 24) begin : g_width_check
    $error("cwd_top: CNT_W must be 24 for the longest rate");
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave.

  logic wait_q;
  logic [31:0] rdata_q;
  cwd_ctrl_t ctrl_q, ctrl_d;
  logic once_q, once_d;
  logic csel_q, csel_d;
  logic armed_q, armed_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  cwd_evt_t sts_q, sts_d, msk_q, msk_d;
  logic rst_q, irq_q, frz_q;

  wire req = AVS_READ | AVS_WRITE;
  wire acc = req & ~wait_q;
  wire [2:0] widx = AVS_ADDRESS[4:2];
  wire wr = acc & AVS_WRITE;
  wire wr_ctrl = wr & (widx == `CWD_OFS_CTRL);
  wire wr_arm = wr & (widx == `CWD_OFS_ARM);
  wire wr_cfg = wr & (widx == `CWD_OFS_CFG);
  wire wr_sts = wr & (widx == `CWD_OFS_STS);
  wire wr_msk = wr & (widx == `CWD_OFS_MSK);
  wire [7:0] wd = AVS_WRITEDATA[7:0];
  wire [2:0] wd_rate = wd[2:0];
  wire wd_win = wd[`CWD_BIT_WIN];
  wire wd_halt = wd[`CWD_BIT_HALT];
  wire wd_mask = wd[`CWD_BIT_MASK];
  wire enabled = ctrl_q.rate != `CWD_RATE_OFF;

  // Mask bit and bits 4..3 read back as zero.
  wire [7:0] ctrl_rd = {ctrl_q.window, ctrl_q.halt, 3'h0, ctrl_q.rate};
  wire [31:0] info_rd = {cnt_q, 5'h00, armed_q, once_q, enabled};
  wire [31:0] rd_mux =
    (widx == `CWD_OFS_CTRL) ? {24'h000000, ctrl_rd} :
    (widx == `CWD_OFS_CFG) ? {31'h00000000, csel_q} :
    (widx == `CWD_OFS_STS) ? {29'h00000000, sts_q} :
    (widx == `CWD_OFS_MSK) ? {29'h00000000, msk_q} :
    (widx == `CWD_OFS_INFO) ? info_rd :
    32'h00000000; // Arm register and unmapped words read zero

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register.

  wire special = SYS.special;
  wire eff = wr_ctrl & ~wd_mask & (special | ~once_q);
  wire halt_rise = ~ctrl_q.halt & ctrl_d.halt;

  always_comb begin
    ctrl_d = ctrl_q;
    once_d = once_q;
    if (NVM_LOAD) begin
      ctrl_d = NVM_CTRL;
    end else if (wr_ctrl) begin
      ctrl_d.halt = special ? wd_halt : (ctrl_q.halt | wd_halt);
      if (eff) begin
        if (special) begin
          ctrl_d.window = wd_win;
          ctrl_d.rate = wd_rate;
        end else begin
          once_d = 1'b1;
          ctrl_d.window = ctrl_q.window | wd_win;
          if (wd_rate != `CWD_RATE_OFF) begin
            ctrl_d.rate = wd_rate;
          end
        end
      end
    end
  end

  // Losing the oscillator drops the source back to the RC clock.
  assign csel_d = wr_cfg ? wd[0] : (csel_q & SYS.osc_up);

  ////////////////////////////////////////////////////////////////////////
  // Timeout counter.

  wire forced = enabled & SYS.debug & ~ctrl_q.halt & special;
  wire [2:0] rate_eff = forced ? `CWD_RATE_MAX : ctrl_q.rate;
  wire win_eff = ctrl_q.window & ~forced;

  function automatic logic [4:0] rate_exp(input logic [2:0] r);
    case (r)
      3'h1: rate_exp = `CWD_EXP_1;
      3'h2: rate_exp = `CWD_EXP_2;
      3'h3: rate_exp = `CWD_EXP_3;
      3'h4: rate_exp = `CWD_EXP_4;
      3'h5: rate_exp = `CWD_EXP_5;
      3'h6: rate_exp = `CWD_EXP_6;
      default: rate_exp = `CWD_EXP_7;
    endcase
  endfunction : rate_exp

  wire [CNT_W:0] period = {{CNT_W{1'b0}}, 1'b1} << rate_exp(rate_eff);
  wire [CNT_W-1:0] last = CNT_W'(period - 1'b1);
  // Window opens after three quarters of the selected period.
  wire [CNT_W-1:0] quarter = CNT_W'(period >> 2);
  wire [CNT_W-1:0] win_open = CNT_W'({quarter, 1'b0} + {1'b0, quarter});

  wire wtick = csel_q ? OSC_TICK : IRC_TICK;
  wire dbg_hold = SYS.debug & ctrl_q.halt;
  wire stop_keep = SYS.pstop & csel_q & SYS.osc_cont;
  wire stop_hold = SYS.stop & ~stop_keep;
  wire run = enabled & wtick & ~dbg_hold & ~stop_hold;

  wire arm_on = wr_arm & enabled;
  wire key1 = wd == `CWD_KEY_FIRST;
  wire key2 = wd == `CWD_KEY_SECOND;
  wire win_err = arm_on & win_eff & (cnt_q < win_open);
  wire key_err = arm_on & ~key1 & ~key2;
  wire key_ok = arm_on & key2 & armed_q & ~win_err;
  wire timeout = run & (cnt_q == last);
  wire fire = timeout | key_err | win_err;

  wire nvm_start = NVM_LOAD & (NVM_CTRL.rate != `CWD_RATE_OFF);
  wire norm_rst = ~special & ((eff & (wd_rate != `CWD_RATE_OFF)) |
                  (eff & wd_win) | (wr_ctrl & halt_rise));
  wire spec_rst = special & wr_ctrl;
  wire csel_rst = csel_d != csel_q;
  wire restart = nvm_start | norm_rst | spec_rst | csel_rst | key_ok |
                 fire;

  always_comb begin
    cnt_d = cnt_q;
    if (restart) begin
      cnt_d = '0;
    end else if (run) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_comb begin
    armed_d = armed_q;
    if (restart) begin
      armed_d = 1'b0;
    end else if (arm_on & key1 & ~win_err) begin
      armed_d = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event status and mask; a new event wins over a write-one clear.

  wire cwd_evt_t evt = '{window_err: win_err, key_err: key_err,
                         timeout: timeout};
  wire [2:0] clr = wr_sts ? wd[2:0] : 3'h0;
  assign sts_d = (sts_q & ~clr) | evt;
  assign msk_d = wr_msk ? wd[2:0] : msk_q;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_q <= '{window: 1'b0, halt: 1'b0, rate: `CWD_RST_RATE};
      once_q <= 1'b0;
      csel_q <= 1'b0;
      armed_q <= 1'b0;
      cnt_q <= '0;
      sts_q <= `CWD_RST_STS;
      msk_q <= `CWD_RST_MSK;
      rst_q <= 1'b0;
      irq_q <= 1'b0;
      frz_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      once_q <= once_d;
      csel_q <= csel_d;
      armed_q <= armed_d;
      cnt_q <= cnt_d;
      sts_q <= sts_d;
      msk_q <= msk_d;
      rst_q <= fire;
      irq_q <= |(sts_q & msk_q);
      frz_q <= dbg_hold;
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;
  assign SYS_RESET = rst_q;
  assign IRQ = irq_q;
  assign PERIODIC_FREEZE = frz_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_first_key;
    arm_on && key1 && !win_err;
  endsequence

  sequence s_second_key;
    arm_on && key2 && !win_err && !key_err && !timeout && !NVM_LOAD;
  endsequence

  property p_halt_keep;
    wr_ctrl && !special && ctrl_q.halt && !wd_halt && !NVM_LOAD
      |=> ctrl_q.halt;
  endproperty
  a_halt_keep: assert property (p_halt_keep)
    else $error("halt bit cleared in normal mode");

  property p_once;
    wr_ctrl && !special && once_q && !NVM_LOAD |=> $stable(ctrl_q.rate)
      && $stable(ctrl_q.window);
  endproperty
  a_once: assert property (p_once)
    else $error("second normal write changed fields");

  property p_zero_rate;
    wr_ctrl && !special && !once_q && !wd_mask && wd_rate == 3'h0 &&
      !NVM_LOAD |=> once_q && $stable(ctrl_q.rate);
  endproperty
  a_zero_rate: assert property (p_zero_rate)
    else $error("zero rate write mishandled");

  property p_mask;
    wr_ctrl && wd_mask && !NVM_LOAD |=> $stable(ctrl_q.rate) &&
      $stable(ctrl_q.window) && $stable(once_q);
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked write changed fields");

  property p_spec_restart;
    wr_ctrl && special |=> cnt_q == '0;
  endproperty
  a_spec_restart: assert property (p_spec_restart)
    else $error("special write did not restart");

  property p_timeout;
    run && cnt_q == last |=> SYS_RESET && cnt_q == '0;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not reset");

  property p_bad_key;
    arm_on && !key1 && !key2 |=> SYS_RESET && sts_q.key_err;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("bad key not punished");

  property p_disabled_arm;
    wr_arm && !enabled && !timeout |=> !SYS_RESET && $stable(armed_q);
  endproperty
  a_disabled_arm: assert property (p_disabled_arm)
    else $error("arm write acted while disabled");

  property p_window;
    arm_on && win_eff && cnt_q < win_open |=> SYS_RESET;
  endproperty
  a_window: assert property (p_window)
    else $error("early arm write not punished");

  property p_first_key;
    s_first_key ##0 !restart |=> armed_q;
  endproperty
  a_first_key: assert property (p_first_key)
    else $error("first key not remembered");

  property p_key_seq;
    armed_q ##0 s_second_key |=> cnt_q == '0 && !armed_q;
  endproperty
  a_key_seq: assert property (p_key_seq)
    else $error("key pair did not restart");

  property p_forced;
    enabled && SYS.debug && !ctrl_q.halt && special |->
      last == 24'hffffff && !win_eff;
  endproperty
  a_forced: assert property (p_forced)
    else $error("debug period not forced");

  property p_csel;
    csel_q && !SYS.osc_up && !wr_cfg |=> !csel_q && cnt_q == '0;
  endproperty
  a_csel: assert property (p_csel)
    else $error("source loss did not restart");

  property p_stop;
    SYS.stop && !stop_keep && !restart |=> $stable(cnt_q);
  endproperty
  a_stop: assert property (p_stop)
    else $error("counter ran in stop");

endmodule : cwd_top

//--- testbench/cwd_top_test.sv
// Self-checking bench for the watchdog control block.
`timescale 1ns/1ps
module cwd_top_test;
  import cwd_pkg::*;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, irc = 1, osc = 0, ld = 0;
  logic [4:0] adr = '0;
  logic [31:0] wd = '0, rdata, q, seed = 32'hc36c;
  logic waitreq, srst, frz, irq;
  logic [7:0] c, v;
  cwd_sys_t sys = '0;
  cwd_ctrl_t nctl = '0;
  int error_cnt = 0, check_count = 0, rst_cnt = 0, n;

  cwd_top DUT (.CORE_CLK(clk), .RSTN(rstn), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .SYS(sys),
    .IRC_TICK(irc), .OSC_TICK(osc), .NVM_LOAD(ld), .NVM_CTRL(nctl),
    .SYS_RESET(srst), .PERIODIC_FREEZE(frz), .IRQ(irq));

  initial forever #50 clk = ~clk;

  // The oscillator ticks at half rate so both sources see traffic.
  always @(posedge clk) begin
    osc <= ~osc;
    if (srst === 1'b1) rst_cnt++;
  end

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Next control read-back after a special-mode write.
  function automatic logic [7:0] nxt(input logic [7:0] o,
                                     input logic [7:0] w);
    nxt = w[5] ? {o[7], w[6], 3'b0, o[2:0]} : {w[7], w[6], 3'b0, w[2:0]};
  endfunction : nxt

  task automatic finish_test();
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      finish_test();
    end
  endtask : bus

  task automatic rchk(input logic [4:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    bus(1'b0, a, 8'h0);
    chk(q & m, e);
  endtask : rchk

  // Two counter reads a few cycles apart must agree.
  task automatic frozen();
    logic [31:0] p;
    repeat (2) @(posedge clk);
    bus(1'b0, 5'h14, 8'h0);
    p = q;
    rchk(5'h14, 32'hffff_ff00, p & 32'hffff_ff00);
  endtask : frozen

  task automatic do_reset(input logic spec);
    @(posedge clk);
    rstn <= 1'b0;
    sys <= '{special: spec, osc_up: 1'b1, default: 1'b0};
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rst_cnt = 0;
  endtask : do_reset

  task automatic wait_rst(input int lim);
    n = 0;
    rst_cnt = 0;
    while (rst_cnt == 0 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_rst

  ////////////////////////////////////////////////////////////////////
  initial begin
    // Normal mode: once-write, mask and disabled arm register.
    do_reset(1'b0);
    rchk(5'h00, 32'hffff_ffff, 0);
    rchk(5'h14, 32'hffff_ffff, 0);
    bus(1'b1, 5'h04, 8'h12);
    repeat (5) @(posedge clk);
    chk(rst_cnt, 0);
    rchk(5'h04, 32'hffff_ffff, 0);
    bus(1'b1, 5'h1c, 8'hff);
    rchk(5'h18, 32'hffff_ffff, 0);
    bus(1'b1, 5'h00, 8'he1);
    rchk(5'h00, 32'hffff_ffff, 8'h40);
    rchk(5'h14, 32'h2, 0);
    bus(1'b1, 5'h00, 8'h00);
    rchk(5'h00, 32'hffff_ffff, 8'h40);
    rchk(5'h14, 32'h3, 2);
    bus(1'b1, 5'h00, 8'h81);
    rchk(5'h00, 32'hff, 8'h40);
    ld <= 1'b1;
    nctl <= '{window: 1'b0, halt: 1'b0, rate: 3'h1};
    @(posedge clk);
    ld <= 1'b0;
    repeat (100) @(posedge clk);
    bus(1'b0, 5'h14, 8'h0);
    chk(q[31:8] >= 24'd90, 1);

    // Normal mode: keys, halt rise, debug freeze, timeout, interrupt.
    do_reset(1'b0);
    bus(1'b1, 5'h00, 8'h01);
    rchk(5'h14, 32'h1, 1);
    bus(1'b1, 5'h04, 8'h55);
    rchk(5'h14, 32'h4, 4);
    repeat (100) @(posedge clk);
    bus(1'b1, 5'h00, 8'h41);
    rchk(5'h14, 32'hffff_f000, 0);
    sys.debug <= 1'b1;
    frozen();
    chk(frz, 1);
    sys.debug <= 1'b0;
    sys.stop <= 1'b1;
    frozen();
    sys.stop <= 1'b0;
    bus(1'b1, 5'h04, 8'h55);
    bus(1'b1, 5'h04, 8'haa);
    rchk(5'h14, 32'hffff_f004, 0);
    wait_rst(20000);
    chk(n > 16370 && n < 16390, 1);
    rchk(5'h0c, 32'h7, 1);
    bus(1'b1, 5'h10, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    bus(1'b1, 5'h0c, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    // The timeout pulse above was already counted; count afresh.
    rst_cnt = 0;
    bus(1'b1, 5'h04, 8'h12);
    repeat (5) @(posedge clk);
    chk(rst_cnt, 1);
    rchk(5'h0c, 32'h2, 2);
    chk(irq, 0);

    // Window mode: early write refused, late key pair accepted.
    do_reset(1'b0);
    bus(1'b1, 5'h00, 8'h81);
    bus(1'b1, 5'h04, 8'h55);
    repeat (5) @(posedge clk);
    chk(rst_cnt, 1);
    rchk(5'h0c, 32'h4, 4);
    repeat (12400) @(posedge clk);
    bus(1'b1, 5'h04, 8'h55);
    bus(1'b1, 5'h04, 8'h55);
    bus(1'b1, 5'h04, 8'haa);
    rchk(5'h14, 32'hffff_f000, 0);
    chk(rst_cnt, 1);

    // Special mode: random control writes, each restarting the count.
    do_reset(1'b1);
    c = 8'h0;
    for (int i = 0; i < 12; i++) begin
      v = 8'(rnd());
      if (i == 0) v = 8'h67;
      if (i == 1) v = 8'h21;
      bus(1'b1, 5'h00, v);
      c = nxt(c, v);
      rchk(5'h00, 32'hff, c);
      rchk(5'h14, 32'hffff_f000, 0);
    end
    bus(1'b1, 5'h00, 8'h01);
    repeat (50) @(posedge clk);
    bus(1'b1, 5'h08, 8'h01);
    rchk(5'h14, 32'hffff_f000, 0);
    // Pseudo-stop on the oscillator with continue set keeps counting.
    sys.stop <= 1'b1;
    sys.pstop <= 1'b1;
    sys.osc_cont <= 1'b1;
    repeat (40) @(posedge clk);
    bus(1'b0, 5'h14, 8'h0);
    chk(q[31:8] >= 24'd16, 1);
    sys.stop <= 1'b0;
    sys.osc_up <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(5'h08, 32'h1, 0);
    sys.debug <= 1'b1;
    rst_cnt = 0;
    repeat (17000) @(posedge clk);
    chk(rst_cnt, 0);
    finish_test();
  end
endmodule : cwd_top_test
